// ===== core/ecgds_core.sv
// Gang sync, sample timing, decimation chain and APB registers of the ECG front end.
`timescale 1ns/1ps
module ecgds_core
    import ecgds_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic               sync_gang_i,
    output logic                    sync_gang_o,
    output logic                    sync_gang_oe,
    input  wire logic               clk_io_i,
    output logic                    clk_io_o,
    output logic                    clk_io_oe,
    output logic                    cal_dac_oe,
    output logic                    common_level_output_en,
    output logic                    common_level_input_sel,
    output logic                    adc_strobe,
    input  wire logic signed [15:0] adc_sample,
    output logic signed [23:0]      ecg_data,
    output logic                    ecg_valid,
    output logic                    pace_if_en,
    output logic [15:0]             pace_data,
    output logic                    pace_valid
);
    ecgds_regs_t r, n;

    logic               gang, master, slave, conv, lowp;
    logic [1:0]         rate, corner;
    logic               sync_edge, strobe, wr, rd, hit, at_end;
    logic [3:0]         dec_log, drop;
    logic [9:0]         dec_last;
    logic [3:0]         pace_last;
    logic signed [25:0] sum_now, sum_norm;
    logic signed [23:0] dec_word, filt, masked;
    logic signed [39:0] trimmed;
    logic [23:0]        delay_app, delay_abs;
    logic [24:0]        acc_add;

    assign gang   = r.ctrl[ECGDS_GANG_BIT];
    assign master = r.ctrl[ECGDS_MASTER_BIT];
    assign slave  = gang & ~master;
    assign conv   = r.ctrl[ECGDS_CONV_BIT];
    assign lowp   = r.ctrl[ECGDS_LOWP_BIT];
    assign rate   = r.cfg[ECGDS_RATE_LSB +: 2];
    assign corner = r.cfg[ECGDS_CORN_LSB +: 2];

    // The shared clock is synchronous here, so a slave samples on each of its edges.
    assign sync_edge = sync_gang_i & ~r.sync_prev;
    assign strobe    = slave ? (clk_io_i ^ r.clk_prev)
                             : (r.acc + acc_add >= ECGDS_CLK_HZ);
    assign acc_add   = lowp ? ECGDS_FS_LP_HZ : ECGDS_FS_HP_HZ;

    // Low power halves the sample rate, so one fewer decimation stage is needed.
    always_comb begin
        case (rate)
            ECGDS_RATE_16K: begin
                dec_log = ECGDS_DEC_HP_16K;
                drop    = ECGDS_DROP_16K;
                delay_app = ECGDS_DLY_16K_NS;
            end
            ECGDS_RATE_2K: begin
                dec_log = ECGDS_DEC_HP_2K;
                drop    = ECGDS_DROP_2K;
                case (corner)
                    2'h0:    delay_app = ECGDS_DLY_450_NS;
                    2'h1:    delay_app = ECGDS_DLY_250_NS;
                    2'h2:    delay_app = ECGDS_DLY_150_NS;
                    default: delay_app = ECGDS_DLY_40_NS;
                endcase
            end
            default: begin
                dec_log = ECGDS_DEC_HP_128K;
                drop    = ECGDS_DROP_128K;
                delay_app = 24'h000000;
            end
        endcase
        if (lowp) begin
            dec_log = dec_log - 4'h1;
        end
    end

    assign delay_abs = delay_app + ECGDS_DLY_FIX_NS;
    assign dec_last  = 10'((11'h001 << dec_log) - 11'h001);
    assign pace_last = 4'((5'h01 << (dec_log - (ECGDS_DEC_HP_2K - ECGDS_DEC_HP_128K) * 4'(rate == ECGDS_RATE_2K)
                          - (ECGDS_DEC_HP_16K - ECGDS_DEC_HP_128K) * 4'(rate == ECGDS_RATE_16K))) - 5'h01);
    assign at_end    = (r.dcnt == dec_last);
    assign sum_now   = r.sum + 26'(adc_sample);
    assign sum_norm  = sum_now <<< (ECGDS_DEC_MAX - dec_log);
    assign dec_word  = sum_norm[25:2];
    // One first-order stage whose shift sets the corner; only the 2 kHz path uses it.
    assign filt      = (rate == ECGDS_RATE_2K)
                       ? r.lp + ((dec_word - r.lp) >>> corner)
                       : dec_word;
    assign trimmed   = filt * $signed({1'b0, r.trim[14:0]});
    assign masked    = 24'(trimmed >>> ECGDS_TRIM_FRAC) & ~24'((25'h0000001 << drop) - 25'h0000001);

    assign wr  = psel & ~penable & pwrite;
    assign rd  = psel & ~penable & ~pwrite;
    assign hit = (paddr == ECGDS_CTRL_OFF) | (paddr == ECGDS_CFG_OFF) | (paddr == ECGDS_TRIM_OFF)
               | (paddr == ECGDS_STAT_OFF) | (paddr == ECGDS_DELAY_OFF);

    always_comb begin
        n           = r;
        n.valid     = 1'b0;
        n.pvalid    = 1'b0;
        n.sync_prev = sync_gang_i;
        n.clk_prev  = clk_io_i;
        n.conv_prev = conv;
        // Writes land in the setup cycle so the access cycle can answer at once.
        if (psel & ~penable) begin
            n.pslverr = ~hit;
            n.prdata  = 32'h00000000;
        end
        if (wr) begin
            case (paddr)
                ECGDS_CTRL_OFF: n.ctrl = pwdata[5:0];
                ECGDS_CFG_OFF:  n.cfg  = pwdata[5:0];
                ECGDS_TRIM_OFF: n.trim = pwdata[15:0];
                default:        n.ctrl = r.ctrl;
            endcase
        end
        if (rd) begin
            case (paddr)
                ECGDS_CTRL_OFF:  n.prdata = {26'h0000000, r.ctrl};
                ECGDS_CFG_OFF:   n.prdata = {26'h0000000, r.cfg};
                ECGDS_TRIM_OFF:  n.prdata = {16'h0000, r.trim};
                ECGDS_STAT_OFF:  n.prdata = {28'h0000000, r.sync_out, 1'b0, r.state};
                ECGDS_DELAY_OFF: n.prdata = {8'h00, delay_abs};
                default:         n.prdata = 32'h00000000;
            endcase
        end
        if (!gang) begin
            n.sync_out = 1'b0;
        end else if (master && conv && !r.conv_prev) begin
            n.sync_out = 1'b1;
        end
        n.acc = strobe && !slave ? r.acc + acc_add - ECGDS_CLK_HZ
                                 : (slave ? 25'h0000000 : r.acc + acc_add);
        if (strobe) begin
            n.clk_tog = ~r.clk_tog;
        end
        case (r.state)
            ECGDS_IDLE: begin
                if (conv) begin
                    n.state = slave ? ECGDS_WAIT : ECGDS_RUN;
                end
            end
            ECGDS_WAIT: begin
                if (!conv) begin
                    n.state = ECGDS_IDLE;
                end else if (sync_edge) begin
                    n.state = ECGDS_RUN;
                end
            end
            ECGDS_RUN: begin
                if (!conv) begin
                    n.state = ECGDS_IDLE;
                end else if (strobe) begin
                    n.dcnt = at_end ? 10'h000 : r.dcnt + 10'h001;
                    n.sum  = at_end ? 26'sh0000000 : sum_now;
                    n.psum = (r.pcnt == pace_last) ? 20'sh00000 : r.psum + 20'(adc_sample);
                    n.pcnt = (r.pcnt == pace_last) ? 4'h0 : r.pcnt + 4'h1;
                    if (at_end) begin
                        n.lp    = filt;
                        n.data  = masked;
                        n.valid = 1'b1;
                    end
                    if (r.pcnt == pace_last && r.cfg[ECGDS_PACE_BIT]) begin
                        n.pdata  = 16'((r.psum + 20'(adc_sample)) >>> ECGDS_DEC_HP_128K);
                        n.pvalid = 1'b1;
                    end
                end
            end
            default: n.state = ECGDS_IDLE;
        endcase
        if (n.state != ECGDS_RUN) begin
            n.dcnt = 10'h000;
            n.sum  = 26'sh0000000;
            n.lp   = 24'sh000000;
            n.pcnt = 4'h0;
            n.psum = 20'sh00000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r       <= '0;
            r.state <= ECGDS_IDLE;
            r.ctrl  <= ECGDS_CTRL_RST;
            r.cfg   <= ECGDS_CFG_RST;
            r.trim  <= ECGDS_TRIM_RST;
        end else begin
            r <= n;
        end
    end

    assign pready                 = 1'b1;
    assign prdata                 = r.prdata;
    assign pslverr                = r.pslverr;
    assign sync_gang_o            = r.sync_out;
    assign sync_gang_oe           = gang & master;
    assign clk_io_o               = r.clk_tog;
    assign clk_io_oe              = gang & master;
    assign cal_dac_oe             = gang & master & r.cfg[ECGDS_CAL_BIT];
    assign common_level_output_en = gang & master;
    assign common_level_input_sel = slave;
    assign adc_strobe             = strobe & (r.state == ECGDS_RUN);
    assign ecg_data               = r.data;
    assign ecg_valid              = r.valid;
    assign pace_if_en             = r.cfg[ECGDS_PACE_BIT];
    assign pace_data              = r.pdata;
    assign pace_valid             = r.pvalid;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_master_start;
        gang && master && conv && !r.conv_prev && !r.sync_out;
    endsequence
    sequence s_edge_out;
        ##1 $rose(sync_gang_o) ##1 sync_gang_o;
    endsequence

    a_sync_dir_off:   assert property (!gang |-> !sync_gang_oe && !clk_io_oe)
        else $error("gang pins driven outside gang mode");
    a_slave_pins_in:  assert property (slave |-> !sync_gang_oe && !clk_io_oe)
        else $error("slave drives a gang pin");
    a_master_drives:  assert property (gang && master |-> sync_gang_oe && clk_io_oe)
        else $error("master does not drive gang pins");
    a_sync_one_edge:  assert property (s_master_start |-> s_edge_out)
        else $error("master sync edge missing");
    a_sync_no_fall:   assert property (gang && $past(gang) && sync_gang_o |=> sync_gang_o || !gang)
        else $error("second sync edge in gang mode");
    a_slave_holdoff:  assert property (r.state == ECGDS_WAIT && !sync_edge && conv
                                       |=> r.state == ECGDS_WAIT)
        else $error("slave started without sync");
    a_slave_align:    assert property (r.state == ECGDS_WAIT && sync_edge && conv
                                       |=> r.state == ECGDS_RUN)
        else $error("slave missed sync edge");
    a_filter_clear:   assert property (!conv |=> r.sum == 0 && r.lp == 0 && !ecg_valid)
        else $error("filter state survives disable");
    a_usable_bits:    assert property (ecg_valid && rate == ECGDS_RATE_2K
                                       |-> ecg_data[4:0] == 5'h00)
        else $error("2 kHz word carries unusable bits");
    a_cal_route:      assert property (gang && master && !r.cfg[ECGDS_CAL_BIT] |-> !cal_dac_oe)
        else $error("calibration routed without request");
    a_abs_delay:      assert property (rate == ECGDS_RATE_128K |-> delay_abs == ECGDS_DLY_FIX_NS)
        else $error("absolute delay wrong at 128 kHz");
    a_pace_gate:      assert property (pace_valid |-> $past(r.cfg[ECGDS_PACE_BIT]))
        else $error("pace data without enable");
endmodule : ecgds_core

// ===== core/ecgds_pkg.sv
// Constants, register map and types for the gang sync and decimation block.
package ecgds_pkg;
    localparam logic [11:0] ECGDS_CTRL_OFF   = 12'h000;
    localparam logic [11:0] ECGDS_CFG_OFF    = 12'h004;
    localparam logic [11:0] ECGDS_TRIM_OFF   = 12'h008;
    localparam logic [11:0] ECGDS_STAT_OFF   = 12'h00c;
    localparam logic [11:0] ECGDS_DELAY_OFF  = 12'h010;
    localparam int          ECGDS_CONV_BIT   = 2;
    localparam int          ECGDS_LOWP_BIT   = 3;
    localparam int          ECGDS_GANG_BIT   = 4;
    localparam int          ECGDS_MASTER_BIT = 5;
    localparam int          ECGDS_RATE_LSB   = 0;
    localparam int          ECGDS_CORN_LSB   = 2;
    localparam int          ECGDS_CAL_BIT    = 4;
    localparam int          ECGDS_PACE_BIT   = 5;
    localparam logic [5:0]  ECGDS_CTRL_RST   = 6'h00;
    localparam logic [5:0]  ECGDS_CFG_RST    = 6'h00;
    localparam logic [15:0] ECGDS_TRIM_RST   = 16'h4000;
    localparam int          ECGDS_TRIM_FRAC  = 14;
    localparam logic [1:0]  ECGDS_RATE_128K  = 2'h0;
    localparam logic [1:0]  ECGDS_RATE_16K   = 2'h1;
    localparam logic [1:0]  ECGDS_RATE_2K    = 2'h2;
    localparam logic [24:0] ECGDS_CLK_HZ     = 25'h1312d00;
    localparam logic [24:0] ECGDS_FS_HP_HZ   = 25'h01f4000;
    localparam logic [24:0] ECGDS_FS_LP_HZ   = 25'h00fa000;
    localparam logic [3:0]  ECGDS_DEC_HP_128K = 4'h4;
    localparam logic [3:0]  ECGDS_DEC_HP_16K  = 4'h7;
    localparam logic [3:0]  ECGDS_DEC_HP_2K   = 4'ha;
    localparam logic [3:0]  ECGDS_DEC_MAX     = 4'ha;
    localparam logic [3:0]  ECGDS_DROP_128K  = 4'h8;
    localparam logic [3:0]  ECGDS_DROP_16K   = 4'h6;
    localparam logic [3:0]  ECGDS_DROP_2K    = 4'h5;
    localparam logic [23:0] ECGDS_DLY_450_NS = 24'h0f03c0;
    localparam logic [23:0] ECGDS_DLY_250_NS = 24'h1d3878;
    localparam logic [23:0] ECGDS_DLY_150_NS = 24'h291f58;
    localparam logic [23:0] ECGDS_DLY_40_NS  = 24'h7497a8;
    localparam logic [23:0] ECGDS_DLY_16K_NS = 24'h01a9c8;
    localparam logic [23:0] ECGDS_DLY_FIX_NS = 24'h009470;

    typedef enum logic [1:0] {
        ECGDS_IDLE = 2'b00,
        ECGDS_WAIT = 2'b01,
        ECGDS_RUN  = 2'b11
    } ecgds_state_t;

    typedef struct packed {
        ecgds_state_t        state;
        logic [5:0]          ctrl;
        logic [5:0]          cfg;
        logic [15:0]         trim;
        logic [24:0]         acc;
        logic                clk_tog;
        logic                clk_prev;
        logic                sync_out;
        logic                sync_prev;
        logic                conv_prev;
        logic [9:0]          dcnt;
        logic signed [25:0]  sum;
        logic signed [23:0]  lp;
        logic signed [23:0]  data;
        logic                valid;
        logic [3:0]          pcnt;
        logic signed [19:0]  psum;
        logic [15:0]         pdata;
        logic                pvalid;
        logic [31:0]         prdata;
        logic                pslverr;
    } ecgds_regs_t;
endpackage : ecgds_pkg

// ===== bench/ecgds_peer.sv
// Model of the peer master front end: shared sample clock, one sync edge, steady samples.
`timescale 1ns/1ps
module ecgds_peer
    import ecgds_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          go,
    output logic               sync_gang_i,
    output logic               clk_io_i,
    output logic signed [15:0] adc_sample
);
    logic [3:0] div_r;

    // The peer stands for a master in lead output mode beside this electrode-mode slave.
    // A steady sample keeps the decimated words constant, so trim effects show plainly.
    assign adc_sample = 16'sh1230;

    // The shared clock stands still until the peer starts converting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r       <= 4'h0;
            clk_io_i    <= 1'b0;
            sync_gang_i <= 1'b0;
        end else if (go) begin
            sync_gang_i <= 1'b1;
            div_r       <= (div_r == 4'h9) ? 4'h0 : div_r + 4'h1;
            if (div_r == 4'h9) begin
                clk_io_i <= ~clk_io_i;
            end
        end
    end
endmodule : ecgds_peer

// ===== bench/tb.sv
// Self-checking testbench for the gang sync and decimation block.
`timescale 1ns/1ps
module tb;
    import ecgds_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e; logic [5:0] p;} ecgds_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, e, sprev = 0, cprev = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, sync_gang_i, sync_gang_o, sync_gang_oe, clk_io_i, clk_io_o, clk_io_oe;
    logic cal_dac_oe, common_level_output_en, common_level_input_sel, adc_strobe, ecg_valid;
    logic pace_if_en, pace_valid;
    logic signed [15:0] adc_sample;
    logic signed [23:0] ecg_data;
    logic [15:0] pace_data, p1;
    int err_count = 0, cmp_count = 0, stot = 0, vprev = 0, gap = 0, vcnt = 0, srise = 0, ctog = 0, pcnt = 0, s, t;
    wire [5:0] pins = {sync_gang_oe, clk_io_oe, cal_dac_oe, common_level_output_en, common_level_input_sel, pace_if_en};
    ecgds_row_t rows [8] = '{
        '{ECGDS_CTRL_OFF, 32'h00, 32'h00, 1'b0, 6'h00}, '{ECGDS_CTRL_OFF, 32'h10, 32'h10, 1'b0, 6'h02},
        '{ECGDS_CTRL_OFF, 32'h20, 32'h20, 1'b0, 6'h00}, '{ECGDS_CTRL_OFF, 32'h30, 32'h30, 1'b0, 6'h34},
        '{ECGDS_CFG_OFF, 32'h10, 32'h10, 1'b0, 6'h3c}, '{ECGDS_CFG_OFF, 32'h20, 32'h20, 1'b0, 6'h35},
        '{ECGDS_TRIM_OFF, 32'h1234, 32'h1234, 1'b0, 6'h35}, '{12'h014, 32'hff, 32'h00, 1'b1, 6'h35}};
    logic [23:0] dly [6] = '{ECGDS_DLY_450_NS, ECGDS_DLY_250_NS, ECGDS_DLY_150_NS, ECGDS_DLY_40_NS,
                             ECGDS_DLY_16K_NS, 24'h000000};
    logic [31:0] cfgs [6] = '{32'h02, 32'h06, 32'h0a, 32'h0e, 32'h01, 32'h00};

    ecgds_core ecgds_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .sync_gang_i, .sync_gang_o, .sync_gang_oe, .clk_io_i, .clk_io_o, .clk_io_oe, .cal_dac_oe,
        .common_level_output_en, .common_level_input_sel, .adc_strobe, .adc_sample, .ecg_data, .ecg_valid,
        .pace_if_en, .pace_data, .pace_valid);
    ecgds_peer ecgds_peer_i (.pclk, .presetn, .go, .sync_gang_i, .clk_io_i, .adc_sample);

    initial begin
        forever #25 pclk = ~pclk;
    end

    // Sampling on the falling edge keeps the monitor clear of the design's own updates.
    always @(negedge pclk) begin
        if (adc_strobe) stot++;
        if (pace_valid) pcnt++;
        if (ecg_valid) begin
            gap = stot - vprev;
            vprev = stot;
            vcnt++;
        end
        if (sync_gang_o && !sprev) srise++;
        sprev = sync_gang_o;
        if (clk_io_i !== cprev) ctog++;
        cprev = clk_io_i;
    end

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) err_count++;
    endtask : xfer

    task automatic wait_v(input int k);
        int n;
        n = vcnt + k;
        for (int i = 0; i < 40000 && vcnt < n; i++) @(posedge pclk);
        if (vcnt < n) err_count++;
    endtask : wait_v

    task automatic rate(input int lo, input int hi);
        int s0;
        s0 = stot;
        repeat (2000) @(posedge pclk);
        chk("strobe rate", 1, (stot - s0 >= lo) && (stot - s0 <= hi));
    endtask : rate

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (80000) @(posedge pclk);
        err_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge pclk);
        chk("idle pins", 0, pins);
        chk("idle data", 0, {ecg_valid, ecg_data, pace_valid});
        presetn <= 1'b1;
        xfer(0, ECGDS_TRIM_OFF, 0);
        chk("trim reset", 32'h4000, rd);
        foreach (rows[i]) begin
            xfer(1, rows[i].a, rows[i].d);
            chk("pins", rows[i].p, pins);
            xfer(0, rows[i].a, 0);
            chk("rdata", rows[i].r, rd);
            chk("slverr", rows[i].e, e);
        end
        chk("sync idle", 0, srise);
        foreach (cfgs[i]) begin
            xfer(1, ECGDS_CFG_OFF, cfgs[i]);
            xfer(0, ECGDS_DELAY_OFF, 0);
            chk("delay", 32'(dly[i] + ECGDS_DLY_FIX_NS), rd);
        end
        // Master start at 128 kHz in high performance mode with the pace port on.
        xfer(1, ECGDS_CFG_OFF, 32'h20);
        xfer(1, ECGDS_CTRL_OFF, 32'h34);
        wait_v(4);
        chk("gap 128k", 16, gap);
        rate(204, 205);
        xfer(0, ECGDS_STAT_OFF, 0);
        chk("master stat", 32'h0b, rd);
        chk("pace pulses", 1, pcnt > 0);
        p1 = pace_data;
        xfer(1, ECGDS_TRIM_OFF, 32'h2000);
        wait_v(2);
        chk("pace untrimmed", p1, pace_data);
        // Low power at 16 kHz: rewriting conversion must not give a second sync edge.
        xfer(1, ECGDS_CTRL_OFF, 32'h3c);
        xfer(1, ECGDS_CFG_OFF, 32'h21);
        wait_v(3);
        chk("gap 16k", 64, gap);
        chk("usable bits", 0, ecg_data[5:0]);
        rate(102, 103);
        chk("one sync edge", 1, srise);
        chk("data present", 1, ecg_data !== 24'h000000);
        // Low power at 2 kHz with the widest corner: 512 strobes per word, 19 usable bits.
        xfer(1, ECGDS_CFG_OFF, 32'h22);
        wait_v(2);
        chk("gap 2k", 512, gap);
        chk("usable bits 2k", 0, ecg_data[4:0]);
        // Reset in mid-run must clear the filter outputs.
        presetn <= 1'b0;
        @(negedge pclk);
        chk("reset data", 0, {ecg_valid, ecg_data, pins});
        @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, ECGDS_CTRL_OFF, 0);
        chk("reset ctrl", 0, rd);
        // Slave is enabled before its master starts.
        xfer(1, ECGDS_CTRL_OFF, 32'h14);
        s = stot;
        repeat (100) @(posedge pclk);
        chk("slave held", s, stot);
        chk("slave pins", 6'h02, pins);
        xfer(0, ECGDS_STAT_OFF, 0);
        chk("slave wait", 32'h01, rd);
        go <= 1'b1;
        repeat (30) @(posedge pclk);
        xfer(0, ECGDS_STAT_OFF, 0);
        chk("slave run", 32'h03, rd);
        s = stot;
        t = ctog;
        repeat (400) @(posedge pclk);
        chk("slave strobes", 1, (stot - s) - (ctog - t) + 1 <= 2);
        final_report();
    end
endmodule : tb
